// ===== design/rcoc_defs.svh
// Behaviour
// R1: Clock control bit 4 enables converter counting
// R2: Timer A clock: 000 system, 001 system/4
// R3: Mode bit 0 picks overflow source: A/B
// R4: Mode bit 1 enables converter counter mode
// R5: Mode bits 2-3 read zero; 4-7 storage
// R6: High-byte write loads timer with buffered low
// R7: High-byte read returns upper, latches lower byte
// R8: Software reads high byte before low byte
// R9: Timer B counts oscillation, A counts clock
// R10: Timers count together; overflow sets flag
// R11: Terminating overflow stops timers, clears enable
// R12: Timer bytes locked while counting is enabled
// R13: Software picks system or instruction clock
// R14: Low switch bits: 0 closes, 1 opens
// R15: High switch bits 0-3; bits 4-7 zero
// R16: Pull-low needs pair bit and open switch
// R17: Pins used as port: switch bits read zero
// R18: Software clears pull bits for port pins
// R19: Two loadable 16-bit count-up timers
// R20: Low-byte write only fills low buffer
// R21: Overflow past all ones; oscillation synchronised
// R22: Flag stays set until software clears
`ifndef RCOC_DEFS_SVH
`define RCOC_DEFS_SVH

// ----------------------------------------
// Register indexes (byte address = 4 x index)
// ----------------------------------------
`define RCOC_IDX_SW_LOW   8'h1a
`define RCOC_IDX_SW_HIGH  8'h1b
`define RCOC_IDX_PULL     8'h1c
`define RCOC_IDX_CLK_CTRL 8'h22
`define RCOC_IDX_MODE     8'h25
`define RCOC_IDX_TA_LOW   8'h26
`define RCOC_IDX_TA_HIGH  8'h27
`define RCOC_IDX_TB_LOW   8'h28
`define RCOC_IDX_TB_HIGH  8'h29
`define RCOC_IDX_IRQ      8'h2a

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RCOC_RST_SW_LOW   8'hff
`define RCOC_RST_SW_HIGH  4'hf
`define RCOC_RST_PULL     6'h3f
`define RCOC_RST_UNDEF    1'b1

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RCOC_UNDEF_BIT    3
`define RCOC_CNT_EN_BIT   4
`define RCOC_CLK_SEL_LSB  5
`define RCOC_OVB_BIT      0
`define RCOC_MODE_EN_BIT  1
`define RCOC_USER_LSB     4
`define RCOC_FLAG_BIT     4

// ----------------------------------------
// Codes and counts
// ----------------------------------------
`define RCOC_SEL_SYS      3'h0
`define RCOC_SEL_DIV4     3'h1
`define RCOC_PRESC_LAST   2'h3
`define RCOC_RESP_OKAY    2'h0
`define RCOC_RESP_DECERR  2'h3

`endif

// ===== design/rcoc_edge_sync.sv
`timescale 1ns/1ns
`include "rcoc_defs.svh"

module rcoc_edge_sync
    import rcoc_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic async_in,
    output logic      rise
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    rcoc_sync_t s;       // Current state
    rcoc_sync_t next_s;  // Next state

    // Two-stage synchroniser, third stage for edge detect
    always_comb begin
        next_s    = s;
        next_s.s1 = async_in;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
    end

    // Register the state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // Rising edge seen after the second stage only
    assign rise = s.s2 & ~s.s3; // [R21]

endmodule

// ===== design/rcoc_pkg.sv
package rcoc_pkg;

    // Timer state
    typedef struct packed {
        logic [15:0] value;
    } rcoc_timer_t;

    // Synchroniser state
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } rcoc_sync_t;

    // Top-level state: bus slave and registers
    typedef struct packed {
        logic        awv;
        logic [7:0]  awidx;
        logic        wv;
        logic [7:0]  wdata;
        logic        wen;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [7:0]  rdata;
        logic [1:0]  rresp;
        logic [7:0]  sw_low;
        logic [3:0]  sw_high;
        logic [5:0]  pull;
        logic        cnt_en;
        logic [2:0]  clk_sel;
        logic        undef;
        logic        overflow_source_sel;
        logic        mode_en;
        logic [3:0]  user;
        logic        flag;
        logic [7:0]  low_buf_a;
        logic [7:0]  low_buf_b;
        logic [1:0]  presc;
    } rcoc_state_t;

endpackage

// ===== design/rcoc_timer16.sv
`timescale 1ns/1ns
`include "rcoc_defs.svh"

module rcoc_timer16
    import rcoc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        load,
    input  wire logic [15:0] load_val,
    input  wire logic        tick,
    output logic [15:0]      value,
    output logic             wrap
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    rcoc_timer_t s;       // Current count
    rcoc_timer_t next_s;  // Next count

    // Load wins; ticks only count upward
    always_comb begin
        next_s = s;
        if (load) begin
            next_s.value = load_val; // [R19]
        end else if (tick) begin
            next_s.value = s.value + 16'h0001; // [R19]
        end
    end

    // Register the state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign value = s.value;
    // Overflow when stepping past all ones
    assign wrap  = tick & (&s.value); // [R21]

endmodule

// ===== design/rcoc_top.sv
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "rcoc_defs.svh"

module rcoc_top
    import rcoc_pkg::*;
#(
    parameter int ADDR_W = 10
)(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              rc_osc_in,
    input  wire logic              port_a_low_is_io,
    input  wire logic              port_a_high_is_io,
    output logic [11:0]            sensor_switch_on,
    output logic [11:0]            sensor_pull_low_on,
    output logic                   conv_irq_flag
);

    // ----------------------------------------
    // State and helper nets
    // ----------------------------------------
    rcoc_state_t s;        // Registered state
    rcoc_state_t next_s;   // Next state
    logic [15:0] ta_val;   // Timer A count
    logic [15:0] tb_val;   // Timer B count
    logic        ovf_a;    // Timer A wrap pulse
    logic        ovf_b;    // Timer B wrap pulse
    logic        osc_rise; // Synchronised oscillation edge
    logic        run;      // Counting active
    logic        tick_a;   // Timer A step
    logic        tick_b;   // Timer B step
    logic        unlocked; // Timer bytes reachable
    logic        wr_fire;  // Write performed now
    logic        rd_fire;  // Read taken now
    logic [7:0]  ar_idx;   // Read register index
    logic        wr_hi_a;  // Timer A high write
    logic        wr_hi_b;  // Timer B high write
    logic        wr_lo_a;  // Timer A low write
    logic        rd_hi_a;  // Timer A high read
    logic        rd_hi_b;  // Timer B high read
    logic [7:0]  sw_low_rd;  // Low switch view
    logic [3:0]  sw_high_rd; // High switch view
    logic [11:0] sw_open;    // Switch bits per pin
    logic [11:0] pin_rc;     // Pin used as sensor

    // ----------------------------------------
    // Oscillation input and timers
    // ----------------------------------------
    rcoc_edge_sync u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (rc_osc_in),
        .rise     (osc_rise)
    );

    rcoc_timer16 u_timer_a (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .load     (wr_hi_a),
        .load_val ({s.wdata, s.low_buf_a}),
        .tick     (tick_a),
        .value    (ta_val),
        .wrap     (ovf_a)
    );

    rcoc_timer16 u_timer_b (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .load     (wr_hi_b),
        .load_val ({s.wdata, s.low_buf_b}),
        .tick     (tick_b),
        .value    (tb_val),
        .wrap     (ovf_b)
    );

    // ----------------------------------------
    // Counting control
    // ----------------------------------------
    // Both timers only run in converter mode with enable set
    assign run      = s.cnt_en & s.mode_en; // [R1] [R4] [R10]
    // Divide-by-four uses a prescaler cleared while stopped; codes other than 000 and 001 never tick
    assign tick_a   = run & ((s.clk_sel == `RCOC_SEL_SYS) |
                      ((s.clk_sel == `RCOC_SEL_DIV4) &
                       (s.presc == `RCOC_PRESC_LAST))); // [R2] [R9]
    assign tick_b   = run & osc_rise; // [R9]
    // Bytes locked while enabled, and absent outside converter mode
    assign unlocked = s.mode_en & ~s.cnt_en; // [R12] [R4]

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign wr_fire = s.awv & s.wv & ~s.bvalid;
    assign rd_fire = s_axi_arvalid & ~s.rvalid;
    assign ar_idx  = s_axi_araddr[9:2];
    assign wr_hi_a = wr_fire & s.wen & unlocked &
                     (s.awidx == `RCOC_IDX_TA_HIGH); // [R6]
    assign wr_hi_b = wr_fire & s.wen & unlocked &
                     (s.awidx == `RCOC_IDX_TB_HIGH); // [R6]
    assign wr_lo_a = wr_fire & s.wen & unlocked &
                     (s.awidx == `RCOC_IDX_TA_LOW);
    assign rd_hi_a = rd_fire & unlocked & (ar_idx == `RCOC_IDX_TA_HIGH);
    assign rd_hi_b = rd_fire & unlocked & (ar_idx == `RCOC_IDX_TB_HIGH);

    // Pins used as port read their switch bits as zero
    assign sw_low_rd  = {s.sw_low[7:4],
                         s.sw_low[3:0] & {4{~port_a_low_is_io}}}; // [R17]
    assign sw_high_rd = s.sw_high & {4{~port_a_high_is_io}}; // [R15] [R17]

    // Read data for a register index
    function automatic logic [8:0] read_mux(input logic [7:0] idx);
        logic [8:0] r;
        r = {1'b1, 8'h00};
        case (idx)
            `RCOC_IDX_SW_LOW:   r = {1'b1, sw_low_rd};
            `RCOC_IDX_SW_HIGH:  r = {1'b1, 4'h0, sw_high_rd}; // [R15]
            `RCOC_IDX_PULL:     r = {1'b1, 2'h0, s.pull}; // [R16]
            `RCOC_IDX_CLK_CTRL: r = {1'b1, s.clk_sel, s.cnt_en, s.undef, 3'h0};
            `RCOC_IDX_MODE:     r = {1'b1, s.user, 2'h0, s.mode_en, s.overflow_source_sel}; // [R5]
            `RCOC_IDX_TA_HIGH:  r = {1'b1, unlocked ? ta_val[15:8] : 8'h00}; // [R7]
            `RCOC_IDX_TA_LOW:   r = {1'b1, unlocked ? s.low_buf_a : 8'h00}; // [R8]
            `RCOC_IDX_TB_HIGH:  r = {1'b1, unlocked ? tb_val[15:8] : 8'h00}; // [R7]
            `RCOC_IDX_TB_LOW:   r = {1'b1, unlocked ? s.low_buf_b : 8'h00};
            `RCOC_IDX_IRQ:      r = {1'b1, 3'h0, s.flag, 4'h0};
            default:            r = {1'b0, 8'h00};
        endcase
        return r;
    endfunction

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    always_comb begin
        logic [8:0] rd;
        logic       hit;
        rd     = read_mux(ar_idx);
        hit    = 1'b0;
        next_s = s;
        // Prescaler restarts whenever counting is off
        next_s.presc = run ? s.presc + 2'h1 : 2'h0;

        // Write address and data taken in either order
        if (s_axi_awvalid & ~s.awv & ~s.bvalid) begin
            next_s.awv   = 1'b1;
            next_s.awidx = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid & ~s.wv & ~s.bvalid) begin
            next_s.wv    = 1'b1;
            next_s.wdata = s_axi_wdata[7:0];
            next_s.wen   = s_axi_wstrb[0];
        end

        // Perform the write once both halves are held
        if (wr_fire) begin
            next_s.awv    = 1'b0;
            next_s.wv     = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = `RCOC_RESP_OKAY;
            case (s.awidx)
                `RCOC_IDX_SW_LOW: begin
                    if (s.wen) next_s.sw_low = s.wdata; // [R14]
                end
                `RCOC_IDX_SW_HIGH: begin
                    if (s.wen) next_s.sw_high = s.wdata[3:0]; // [R15]
                end
                `RCOC_IDX_PULL: begin
                    if (s.wen) next_s.pull = s.wdata[5:0]; // [R16]
                end
                `RCOC_IDX_CLK_CTRL: begin
                    if (s.wen) begin
                        next_s.cnt_en  = s.wdata[`RCOC_CNT_EN_BIT]; // [R1]
                        next_s.clk_sel = s.wdata[`RCOC_CLK_SEL_LSB +: 3]; // [R2]
                        next_s.undef   = s.wdata[`RCOC_UNDEF_BIT];
                    end
                end
                `RCOC_IDX_MODE: begin
                    if (s.wen) begin
                        next_s.overflow_source_sel     = s.wdata[`RCOC_OVB_BIT]; // [R3]
                        next_s.mode_en = s.wdata[`RCOC_MODE_EN_BIT]; // [R4]
                        next_s.user    = s.wdata[`RCOC_USER_LSB +: 4]; // [R5]
                    end
                end
                `RCOC_IDX_TA_LOW: begin
                    if (s.wen & unlocked) next_s.low_buf_a = s.wdata; // [R20]
                end
                `RCOC_IDX_TB_LOW: begin
                    if (s.wen & unlocked) next_s.low_buf_b = s.wdata; // [R20]
                end
                `RCOC_IDX_TA_HIGH, `RCOC_IDX_TB_HIGH: begin
                    hit = 1'b1; // Load handled by the timer itself
                end
                `RCOC_IDX_IRQ: begin
                    if (s.wen) next_s.flag = s.wdata[`RCOC_FLAG_BIT]; // [R22]
                end
                default: begin
                    next_s.bresp = `RCOC_RESP_DECERR;
                end
            endcase
        end
        if (s.bvalid & s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // Read answer one cycle after the address is taken
        if (rd_fire) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = rd[7:0];
            next_s.rresp  = rd[8] ? `RCOC_RESP_OKAY : `RCOC_RESP_DECERR;
        end else if (s.rvalid & s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        // High read latches the live low byte for a later low read
        if (rd_hi_a) next_s.low_buf_a = ta_val[7:0]; // [R7]
        if (rd_hi_b) next_s.low_buf_b = tb_val[7:0]; // [R7]

        // Either wrap ends the run; hardware clear beats a write
        if (ovf_a | ovf_b) begin
            next_s.cnt_en = 1'b0; // [R11]
        end
        // Selected wrap sets the flag; set beats a clearing write
        if (s.overflow_source_sel ? ovf_b : ovf_a) begin
            next_s.flag = 1'b1; // [R3] [R10] [R22]
        end
        if (hit) next_s.presc = next_s.presc;
    end

    // Register the state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s         <= '0;
            s.sw_low  <= `RCOC_RST_SW_LOW;
            s.sw_high <= `RCOC_RST_SW_HIGH;
            s.pull    <= `RCOC_RST_PULL;
            s.undef   <= `RCOC_RST_UNDEF;
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------
    // Sensor switches and pull-lows
    // ----------------------------------------
    assign sw_open = {s.sw_high, s.sw_low};
    assign pin_rc  = {{4{~port_a_high_is_io}}, 4'hf, {4{~port_a_low_is_io}}};

    // Zero closes a switch; open switch plus pair bit pulls low
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            sensor_switch_on[i]   = pin_rc[i] & ~sw_open[i]; // [R14]
            sensor_pull_low_on[i] = pin_rc[i] & sw_open[i] & s.pull[i/2]; // [R16]
        end
    end

    // ----------------------------------------
    // Bus outputs
    // ----------------------------------------
    assign s_axi_awready = ~s.awv & ~s.bvalid;
    assign s_axi_wready  = ~s.wv & ~s.bvalid;
    assign s_axi_bvalid  = s.bvalid;
    assign s_axi_bresp   = s.bresp;
    assign s_axi_arready = ~s.rvalid;
    assign s_axi_rvalid  = s.rvalid;
    assign s_axi_rdata   = {24'h000000, s.rdata};
    assign s_axi_rresp   = s.rresp;
    assign conv_irq_flag = s.flag;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Steps of a high-byte read and of the divided clock
    sequence hi_read_a_s;
        rd_hi_a;
    endsequence
    sequence div4_tick_s;
        tick_a && s.clk_sel == `RCOC_SEL_DIV4;
    endsequence
    sequence div4_quiet_s;
        !tick_a [*3];
    endsequence

    stop_on_wrap_a: assert property ((ovf_a | ovf_b) |=> !s.cnt_en) // [R11]
        else $error("enable not cleared on overflow");
    flag_on_wrap_a: assert property ((s.overflow_source_sel ? ovf_b : ovf_a) |=> s.flag) // [R10]
        else $error("flag not set on selected overflow");
    flag_hold_a: assert property (s.flag && !(wr_fire && // [R22]
        s.awidx == `RCOC_IDX_IRQ) |=> s.flag)
        else $error("flag dropped without software clear");
    div4_gap_a: assert property (div4_tick_s |=> div4_quiet_s) // [R2]
        else $error("divided clock ticks too often");
    // Timer A holds while stopped; timer B moves only when its own source steps it
    idle_timers_a: assert property (!run |=> $stable(ta_val) || $past(wr_hi_a)) // [R1]
        else $error("timer moved while stopped");
    osc_only_b_a: assert property (!tick_b |=> $stable(tb_val) || $past(wr_hi_b)) // [R9]
        else $error("timer B moved without an edge");
    count_gate_a: assert property (!run |-> !tick_a && !tick_b) // [R10]
        else $error("timer stepped while not running");
    high_load_a: assert property (wr_hi_a |=> // [R6]
        ta_val == {$past(s.wdata), $past(s.low_buf_a)})
        else $error("high write did not load timer");
    low_keep_a: assert property (wr_lo_a |=> $stable(ta_val)) // [R20]
        else $error("low write changed timer");
    high_latch_a: assert property (hi_read_a_s |=> // [R7]
        s.low_buf_a == $past(ta_val[7:0]) &&
        s.rdata == $past(ta_val[15:8]))
        else $error("high read did not latch low byte");
    locked_read_a: assert property ((rd_fire && s.cnt_en && // [R12]
        ar_idx == `RCOC_IDX_TA_HIGH) |=> s.rdata == 8'h00)
        else $error("timer byte readable while counting");
    // Spare register bits stay zero on the bus
    mode_resv_a: assert property ((rd_fire && ar_idx == `RCOC_IDX_MODE) // [R5]
        |=> s.rdata[3:2] == 2'h0)
        else $error("mode reserved bits not zero");
    sw_high_resv_a: assert property ((rd_fire && ar_idx == `RCOC_IDX_SW_HIGH) // [R15]
        |=> s.rdata[7:4] == 4'h0)
        else $error("switch high spare bits not zero");
    pull_resv_a: assert property ((rd_fire && ar_idx == `RCOC_IDX_PULL) // [R16]
        |=> s.rdata[7:6] == 2'h0)
        else $error("pull spare bits not zero");
    pull_gate_a: assert property (sensor_pull_low_on[0] |-> // [R16]
        s.sw_low[0] && s.pull[0] && !sensor_switch_on[0])
        else $error("pull-low on with switch closed");
    port_mask_a: assert property (port_a_high_is_io |-> // [R17]
        sensor_switch_on[11:8] == 4'h0 && sensor_pull_low_on[11:8] == 4'h0)
        else $error("port pin still wired to sensor");

endmodule

// ===== tb/rcoc_osc_model.sv
`timescale 1ns/1ns
// RC sensor oscillation; holds low while stopped
module rcoc_osc_model #(
    parameter int HALF_NS = 165
)(
    input  wire logic run,
    output logic      osc
);
    // Half period off the bus clock grid, so edges drift in phase
    initial osc = 1'b0;
    always begin
        #(HALF_NS);
        osc = run ? ~osc : 1'b0;
    end
endmodule

// ===== tb/rcoc_top_bench.sv
`timescale 1ns/1ns
module rcoc_top_bench
    import rcoc_pkg::*;
;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [9:0]  awa = '0;
    logic [9:0]  ara = '0;
    logic [31:0] wd = '0;
    logic        awv = 1'b0;
    logic        wv = 1'b0;
    logic        bre = 1'b0;
    logic        arv = 1'b0;
    logic        rre = 1'b0;
    logic        io_lo = 1'b0;
    logic        io_hi = 1'b0;
    logic        run_osc = 1'b0;
    logic        awr, wrd, bv, arr, rv, osc, flag;
    logic [1:0]  br, rr;
    logic [31:0] rd;
    logic [11:0] sw_on, pl_on;
    logic [17:0] rq[$];  // Read notes: mask, resp, data
    logic [1:0]  bq[$];  // Write response notes
    int          mismatches = 0;
    int          tests_run = 0;

    always #25 aclk = ~aclk;

    // Strobes tied: every write stores its low byte
    rcoc_top u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rre), .rc_osc_in(osc),
        .port_a_low_is_io(io_lo), .port_a_high_is_io(io_hi),
        .sensor_switch_on(sw_on), .sensor_pull_low_on(pl_on),
        .conv_irq_flag(flag)
    );
    rcoc_osc_model u_osc (.run(run_osc), .osc(osc));

    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            mismatches++;
            $display("FAIL %s exp %h seen %h", n, e, s);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Bounded wait ran out: count it and stop
    task automatic guard(input int k);
        if (k >= 200) begin
            mismatches++;
            $display("FAIL handshake exp answer seen none");
            conclude();
        end
    endtask

    // Oldest note against each accepted answer
    always @(posedge aclk) begin
        if (rv && rre && rq.size() > 0) begin
            check("rdata", {rr, |rd[31:8], rd[7:0] & rq[0][17:10]},
                  {rq[0][9:8], 1'b0, rq[0][7:0] & rq[0][17:10]});
            void'(rq.pop_front());
        end
        if (bv && bre && bq.size() > 0) begin
            check("bresp", br, bq.pop_front());
        end
    end

    // ----------------------------------------
    // Bus master tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] r = 2'h0);
        int   k;
        logic a;
        logic w;
        bq.push_back(r);
        awa <= {i, 2'b00};
        wd <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        a = 1'b0;
        w = 1'b0;
        for (k = 0; k < 200 && !(a && w); k++) begin
            @(posedge aclk);
            a = a | (awr & awv);
            w = w | (wrd & wv);
            if (a) awv <= 1'b0;
            if (w) wv <= 1'b0;
        end
        guard(k);
        for (k = 0; k < 200 && bv !== 1'b1; k++) @(posedge aclk);
        guard(k);
        bre <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rdq(input logic [7:0] i, input logic [7:0] d,
                       input logic [7:0] m = 8'hff, input logic [1:0] r = 2'h0);
        int k;
        rq.push_back({m, r, d});
        ara <= {i, 2'b00};
        arv <= 1'b1;
        rre <= 1'b1;
        for (k = 0; k < 200 && !(arr && arv); k++) @(posedge aclk);
        guard(k);
        arv <= 1'b0;
        for (k = 0; k < 200 && rv !== 1'b1; k++) @(posedge aclk);
        guard(k);
        rre <= 1'b0;
        @(posedge aclk);
    endtask

    // Expected switch and pull-low outputs
    function automatic logic [23:0] pins(input logic [11:0] s, input logic [5:0] p);
        logic [11:0] pl;
        for (int j = 0; j < 12; j++) pl[j] = s[j] & p[j/2];
        return {~s, pl};
    endfunction

    // One conversion: load, start, wait for flag, stop, read back
    task automatic run(input logic o, input logic [2:0] sel, input logic [15:0] ta,
                       input logic [15:0] tb, input logic os, input int lo, input int hi,
                       input logic f, input logic [7:0] cc, input logic [7:0] am);
        int n;
        wr(8'h25, {7'h1, o});
        wr(8'h2a, 8'h00);
        wr(8'h26, ta[7:0]);
        wr(8'h27, ta[15:8]);
        wr(8'h28, tb[7:0]);
        wr(8'h29, tb[15:8]);
        run_osc <= os;
        wr(8'h22, {sel, 5'h10});  // Clock source code written as given, unlisted codes included
        for (n = 0; n < hi && flag !== 1'b1; n++) @(posedge aclk);
        check("cycles", {n >= lo, n < hi}, {1'b1, f});
        if (cc[4]) begin
            rdq(8'h27, 8'h00);
            wr(8'h27, 8'hff);
        end
        rdq(8'h22, cc);
        rdq(8'h2a, {3'h0, f, 4'h0});
        run_osc <= 1'b0;
        wr(8'h22, 8'h00);
        rdq(8'h27, cc[4] ? ta[15:8] : 8'h00);  // High byte first
        rdq(8'h26, cc[4] ? ta[7:0] : 8'h00, am);
        rdq(8'h29, 8'h00);
        rdq(8'h28, 8'h00);
        wr(8'h2a, 8'h00);
        rdq(8'h2a, 8'h00);
        $display("test run done");
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] s;
        logic [7:0]  b;
        void'($urandom(32'heaa3));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdq(8'h1a, 8'hff);
        rdq(8'h1b, 8'h0f);
        rdq(8'h1c, 8'h3f);
        rdq(8'h22, 8'h08);
        rdq(8'h25, 8'h00);
        rdq(8'h30, 8'h00, 8'hff, 2'h3);
        wr(8'h30, 8'h5a, 2'h3);
        wr(8'h1b, 8'hff);
        rdq(8'h1b, 8'h0f);
        wr(8'h25, 8'hfc);
        rdq(8'h25, 8'hf0);
        wr(8'h22, 8'he7);
        rdq(8'h22, 8'he0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            s = $urandom;
            wr(8'h1a, s[7:0]);
            wr(8'h1b, s[15:8]);
            wr(8'h1c, s[23:16]);
            check("pins", {sw_on, pl_on}, pins(s[11:0], s[21:16]));
            rdq(8'h1c, {2'h0, s[21:16]});
        end
        io_lo <= 1'b1;
        io_hi <= 1'b1;
        wr(8'h1c, 8'h0c);  // Pairs on port pins released
        rdq(8'h1a, {s[7:4], 4'h0});
        rdq(8'h1b, 8'h00);
        check("pins", {sw_on, pl_on}, {4'h0, ~s[7:4], 4'h0, 4'h0, s[7:4], 4'h0});
        io_lo <= 1'b0;
        io_hi <= 1'b0;
        wr(8'h25, 8'h00);
        wr(8'h27, 8'h77);
        wr(8'h25, 8'h02);
        rdq(8'h27, 8'h00);
        for (b = 8'h26; b < 8'h2a; b = b + 8'h2) begin
            wr(b, 8'h34);
            rdq(b + 8'h1, 8'h00);
            wr(b, 8'h34);
            wr(b + 8'h1, 8'h12);
            wr(b, 8'haa);
            rdq(b + 8'h1, 8'h12);
            rdq(b, 8'h34);
        end
        $display("test bytes done");
        run(1'b0, 3'h1, 16'hfff0, 16'h0000, 1'b0, 56, 90, 1'b1, 8'h20, 8'hff);
        run(1'b1, 3'h0, 16'hfff8, 16'h0000, 1'b0, 40, 40, 1'b0, 8'h00, 8'hff);
        run(1'b1, 3'h0, 16'h0000, 16'hfffe, 1'b1, 2, 80, 1'b1, 8'h00, 8'h00);
        run(1'b0, 3'h2, 16'h0055, 16'h0000, 1'b0, 30, 30, 1'b0, 8'h50, 8'hff);
        conclude();
    end
endmodule
